// ### src/fic_regs.svh
// Device register offsets, control bit positions, mode codes and unlock key bytes
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH

`define FIC_CTL0 8'h69
`define FIC_CTL2 8'h6b
`define FIC_ADRL 8'h6c
`define FIC_ADRH 8'h6d
`define FIC_DAT0L 8'h6e
`define FIC_DAT0H 8'h6f
`define FIC_DAT1L 8'h70
`define FIC_DAT1H 8'h71
`define FIC_DAT2L 8'h72
`define FIC_DAT2H 8'h73
`define FIC_DAT3L 8'h74
`define FIC_DAT3H 8'h75

`define FIC_CTL0_ENA 7
`define FIC_CTL0_MODE_HI 6
`define FIC_CTL0_MODE_LO 4
`define FIC_CTL0_UNLK 3
`define FIC_CTL0_PROG 2
`define FIC_CTL0_RDEN 1
`define FIC_CTL0_RDGO 0
`define FIC_CTL2_CLR 0

`define FIC_MODE_WRITE 3'h0
`define FIC_MODE_ERASE 3'h1
`define FIC_MODE_READ 3'h3
`define FIC_MODE_UNLOCK 3'h6

`define FIC_KEY0 8'h00
`define FIC_KEY1 8'h0d
`define FIC_KEY2 8'hc3
`define FIC_KEY3 8'h04
`define FIC_KEY4 8'h09
`define FIC_KEY5 8'h40
`define FIC_KEY_COUNT 3'h6

`define FIC_PAGE_WORDS 32

`endif

// ### src/fic_pkg.sv
// Types shared by the flash programming controller and its register port
package fic_pkg;

  typedef enum logic [2:0] {
    FIC_OP_UNLOCK = 3'h0,
    FIC_OP_ERASE = 3'h1,
    FIC_OP_WRITE = 3'h2,
    FIC_OP_READ = 3'h3,
    FIC_OP_RELOCK = 3'h4
  } fic_op_t;

  typedef struct packed {
    fic_op_t op;
    logic [12:0] addr;
    logic [5:0] count;
    logic clrBuf;
  } fic_cmd_t;

  typedef struct packed {
    logic isRead;
    logic [7:0] addr;
    logic [7:0] data;
  } fic_req_t;

  typedef enum logic [2:0] {
    FIC_P_IDLE = 3'b001,
    FIC_P_STROBE = 3'b010,
    FIC_P_CAPT = 3'b100
  } fic_port_state_t;

  typedef enum logic [14:0] {
    FIC_S_IDLE = 15'h0001,
    FIC_S_CHKEN = 15'h0002,
    FIC_S_CLRBUF = 15'h0004,
    FIC_S_CLRPOLL = 15'h0008,
    FIC_S_SETMODE = 15'h0010,
    FIC_S_ADDRL = 15'h0020,
    FIC_S_ADDRH = 15'h0040,
    FIC_S_KEYS = 15'h0080,
    FIC_S_DATAL = 15'h0100,
    FIC_S_DATAH = 15'h0200,
    FIC_S_TRIG = 15'h0400,
    FIC_S_POLL = 15'h0800,
    FIC_S_FETCHL = 15'h1000,
    FIC_S_FETCHH = 15'h2000,
    FIC_S_FIN = 15'h4000
  } fic_state_t;

endpackage

// ### src/fic_sfr_port.sv
// Single register read or write toward the device's special function registers
`timescale 1ns/100ps
module fic_sfr_port import fic_pkg::*; (
  input wire logic core_clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic start, // Begin one access
  input fic_req_t req, // Access kind, address, data
  output logic done, // Access finished, one cycle
  output logic [7:0] rdata, // Captured read data
  output logic [7:0] sfrAddr, // Register address to device
  output logic [7:0] sfrWdata, // Write data to device
  output logic sfrWr, // Write strobe
  output logic sfrRd, // Read strobe
  input wire logic [7:0] sfrRdata // Read data, valid one cycle after strobe
);
  fic_port_state_t st, next_st;
  logic next_done, next_sfrWr, next_sfrRd;
  logic [7:0] next_rdata, next_sfrAddr, next_sfrWdata;

  // Strobe for one cycle, then finish or capture read data
  always_comb begin
    next_st = st;
    next_done = 1'b0;
    next_sfrWr = 1'b0;
    next_sfrRd = 1'b0;
    next_rdata = rdata;
    next_sfrAddr = sfrAddr;
    next_sfrWdata = sfrWdata;
    case (st)
      FIC_P_IDLE: begin
        if (start) begin
          next_sfrAddr = req.addr;
          next_sfrWdata = req.isRead ? 8'h00 : req.data;
          next_sfrWr = ~req.isRead;
          next_sfrRd = req.isRead;
          next_st = FIC_P_STROBE;
        end
      end
      FIC_P_STROBE: begin
        if (sfrRd) begin
          next_st = FIC_P_CAPT;
        end else begin
          next_done = 1'b1;
          next_st = FIC_P_IDLE;
        end
      end
      FIC_P_CAPT: begin
        next_rdata = sfrRdata;
        next_done = 1'b1;
        next_st = FIC_P_IDLE;
      end
      default: next_st = FIC_P_IDLE;
    endcase
  end

  // Register the access state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= FIC_P_IDLE;
      done <= 1'b0;
      sfrWr <= 1'b0;
      sfrRd <= 1'b0;
      rdata <= 8'h00;
      sfrAddr <= 8'h00;
      sfrWdata <= 8'h00;
    end else if (ce) begin
      st <= next_st;
      done <= next_done;
      sfrWr <= next_sfrWr;
      sfrRd <= next_sfrRd;
      rdata <= next_rdata;
      sfrAddr <= next_sfrAddr;
      sfrWdata <= next_sfrWdata;
    end
  end
endmodule

// ### src/fic_ctrl.sv
// Flash programming controller: unlock, page erase, buffered write, word read, relock
// Rules this block follows or relies on
// [R1] Erase or write only after enable flag reads high
// [R2] Erase uses mode 001 after clearing buffer
// [R3] Trigger bit starts operation; wait until low
// [R4] Write uses mode 000 and trigger bit
// [R5] Low data byte before high byte per word
// [R6] Separate address load and trigger per scattered word
// [R7] Device halts CPU during operations
// [R8] Device erases whole pages only
// [R9] Device programs buffer as one page
// [R10] Retry write same page after buffer clear
// [R11] Software runs maximum clock while programming
// [R12] Read: mode 011, read enable, address, trigger
// [R13] Device clears read trigger, presents word
// [R14] Reads need no unlock
// [R15] Relock by clearing enable flag when done
// [R16] Device ignores trigger while locked
// [R17] Device sets enable flag on correct key
// [R18] Buffer holds 32 words, one page
// [R19] Each high byte write advances word address; the model holds it at word 31
// [R20] Unlock: mode 110, start bit, six keys
`timescale 1ns/100ps
`include "fic_regs.svh"
module fic_ctrl import fic_pkg::*; #(
  parameter int WORDS = `FIC_PAGE_WORDS
) (
  input wire logic core_clk, // System clock, 250 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic cmdValid, // Start a command when idle
  input fic_cmd_t cmdIn, // Command, flash address, word count, clear flag
  input wire logic bufWr, // Load one word into the host buffer
  input wire logic [4:0] bufIdx, // Buffer index for the load
  input wire logic [15:0] bufData, // Word to load
  output logic busy, // Command in progress
  output logic cmdDone, // Command finished, one cycle
  output logic cmdErr, // Command refused or unlock failed
  output logic [15:0] rdWord, // Word from the last read
  output logic [7:0] sfrAddr, // Device register address
  output logic [7:0] sfrWdata, // Device register write data
  output logic sfrWr, // Device register write strobe
  output logic sfrRd, // Device register read strobe
  input wire logic [7:0] sfrRdata // Device register read data
);
  fic_state_t st, next_st;
  fic_cmd_t cmd, next_cmd;
  logic [5:0] idx, next_idx;
  logic issued, next_issued, progEn, next_progEn, clrSeen, next_clrSeen;
  logic next_busy, next_cmdDone, next_cmdErr;
  logic [15:0] next_rdWord;
  logic opStart, opDone;
  logic [7:0] opRdata, ctlVal, lastWrAddr;
  logic [2:0] mode;
  int trigIdx;
  fic_req_t req;
  logic [15:0] wordBuf [WORDS];

  // Host-side copy of the page data to be programmed
  always_ff @(posedge core_clk) begin
    if (ce && bufWr) begin
      wordBuf[bufIdx] <= bufData;
    end
  end

  // Mode and trigger bit for the command in hand
  always_comb begin
    mode = `FIC_MODE_WRITE;
    trigIdx = `FIC_CTL0_PROG;
    // [R4] [R12] mode codes per command
    case (cmd.op)
      FIC_OP_UNLOCK: begin
        mode = `FIC_MODE_UNLOCK;
        trigIdx = `FIC_CTL0_UNLK;
      end
      FIC_OP_ERASE: mode = `FIC_MODE_ERASE;
      FIC_OP_READ: begin
        mode = `FIC_MODE_READ;
        trigIdx = `FIC_CTL0_RDGO;
      end
      default: mode = `FIC_MODE_WRITE;
    endcase
    ctlVal = 8'h00;
    // [R15] relock clears flag
    ctlVal[`FIC_CTL0_ENA] = (cmd.op == FIC_OP_RELOCK) ? 1'b0 : progEn;
    ctlVal[`FIC_CTL0_MODE_HI:`FIC_CTL0_MODE_LO] = mode;
    ctlVal[`FIC_CTL0_RDEN] = (cmd.op == FIC_OP_READ);
    ctlVal[trigIdx] = (st == FIC_S_TRIG);
  end

  // Command sequencer: one device register access per step
  always_comb begin
    next_st = st;
    next_cmd = cmd;
    next_idx = idx;
    next_issued = issued;
    next_progEn = progEn;
    next_clrSeen = clrSeen;
    next_busy = busy;
    next_cmdDone = 1'b0;
    next_cmdErr = cmdErr;
    next_rdWord = rdWord;
    req = '0;
    opStart = 1'b0;
    case (st)
      FIC_S_CHKEN, FIC_S_CLRPOLL, FIC_S_POLL: req.isRead = 1'b1;
      FIC_S_FETCHL, FIC_S_FETCHH: req.isRead = 1'b1;
      default: req.isRead = 1'b0;
    endcase
    case (st)
      FIC_S_CHKEN, FIC_S_SETMODE, FIC_S_TRIG, FIC_S_POLL: req.addr = `FIC_CTL0;
      FIC_S_CLRBUF, FIC_S_CLRPOLL: begin
        req.addr = `FIC_CTL2;
        req.data[`FIC_CTL2_CLR] = 1'b1;
      end
      FIC_S_ADDRL: req.addr = `FIC_ADRL;
      FIC_S_ADDRH: req.addr = `FIC_ADRH;
      FIC_S_DATAL, FIC_S_FETCHL: req.addr = `FIC_DAT0L;
      FIC_S_DATAH, FIC_S_FETCHH: req.addr = `FIC_DAT0H;
      default: req.addr = `FIC_CTL0;
    endcase
    case (st)
      FIC_S_SETMODE, FIC_S_TRIG: req.data = ctlVal;
      FIC_S_ADDRL: req.data = cmd.addr[7:0];
      FIC_S_ADDRH: req.data = {3'h0, cmd.addr[12:8]};
      // [R5] low byte then high byte
      FIC_S_DATAL: req.data = wordBuf[idx[4:0]][7:0];
      // [R19] dummy tag bytes for erase
      FIC_S_DATAH: req.data = (cmd.op == FIC_OP_ERASE) ? 8'h00 : wordBuf[idx[4:0]][15:8];
      default: ;
    endcase
    // [R20] key byte sequence
    if (st == FIC_S_KEYS) begin
      case (idx[2:0])
        3'h0: req = '{1'b0, `FIC_DAT1L, `FIC_KEY0};
        3'h1: req = '{1'b0, `FIC_DAT2L, `FIC_KEY1};
        3'h2: req = '{1'b0, `FIC_DAT3L, `FIC_KEY2};
        3'h3: req = '{1'b0, `FIC_DAT1H, `FIC_KEY3};
        3'h4: req = '{1'b0, `FIC_DAT2H, `FIC_KEY4};
        default: req = '{1'b0, `FIC_DAT3H, `FIC_KEY5};
      endcase
    end
    if (st != FIC_S_IDLE && st != FIC_S_FIN && !issued) begin
      opStart = 1'b1;
      next_issued = 1'b1;
    end
    if (opDone) begin
      next_issued = 1'b0;
    end
    case (st)
      FIC_S_IDLE: begin
        if (cmdValid) begin
          next_cmd = cmdIn;
          next_idx = 6'h00;
          next_cmdErr = 1'b0;
          next_clrSeen = 1'b0;
          next_busy = 1'b1;
          // [R18] refuse transfers crossing the page
          if ((cmdIn.op == FIC_OP_ERASE || cmdIn.op == FIC_OP_WRITE) &&
              (cmdIn.count == 6'h00 ||
               ({2'b00, cmdIn.addr[4:0]} + {1'b0, cmdIn.count}) > 7'(WORDS))) begin
            next_cmdErr = 1'b1;
            next_st = FIC_S_FIN;
          end else if (cmdIn.op == FIC_OP_ERASE || cmdIn.op == FIC_OP_WRITE) begin
            next_st = FIC_S_CHKEN;
          end else begin
            // [R14] reads skip the enable check
            next_st = FIC_S_SETMODE;
          end
        end
      end
      FIC_S_CHKEN: if (opDone) begin
        next_progEn = opRdata[`FIC_CTL0_ENA];
        // [R1] refuse while locked
        if (!opRdata[`FIC_CTL0_ENA]) begin
          next_cmdErr = 1'b1;
          next_st = FIC_S_FIN;
        // [R10] retry clears buffer first
        end else if (cmd.op == FIC_OP_ERASE || cmd.clrBuf) begin
          next_st = FIC_S_CLRBUF;
        end else begin
          next_st = FIC_S_SETMODE;
        end
      end
      FIC_S_CLRBUF: if (opDone) next_st = FIC_S_CLRPOLL;
      // [R2] wait for buffer clear to finish
      FIC_S_CLRPOLL: if (opDone && !opRdata[`FIC_CTL2_CLR]) begin
        next_clrSeen = 1'b1;
        next_st = FIC_S_SETMODE;
      end
      FIC_S_SETMODE: if (opDone) begin
        if (cmd.op == FIC_OP_RELOCK) begin
          next_progEn = 1'b0;
          next_st = FIC_S_FIN;
        end else if (cmd.op == FIC_OP_UNLOCK) begin
          next_st = FIC_S_TRIG;
        end else begin
          next_st = FIC_S_ADDRL;
        end
      end
      // [R6] address reloaded per command
      FIC_S_ADDRL: if (opDone) next_st = FIC_S_ADDRH;
      FIC_S_ADDRH: if (opDone) begin
        if (cmd.op == FIC_OP_READ) next_st = FIC_S_TRIG;
        else if (cmd.op == FIC_OP_ERASE) next_st = FIC_S_DATAH;
        else next_st = FIC_S_DATAL;
      end
      FIC_S_KEYS: if (opDone) begin
        next_idx = idx + 6'h01;
        if (idx[2:0] == `FIC_KEY_COUNT - 3'h1) next_st = FIC_S_POLL;
      end
      FIC_S_DATAL: if (opDone) next_st = FIC_S_DATAH;
      FIC_S_DATAH: if (opDone) begin
        next_idx = idx + 6'h01;
        if (idx + 6'h01 == cmd.count) next_st = FIC_S_TRIG;
        else if (cmd.op == FIC_OP_WRITE) next_st = FIC_S_DATAL;
      end
      FIC_S_TRIG: if (opDone) begin
        next_idx = 6'h00;
        next_st = (cmd.op == FIC_OP_UNLOCK) ? FIC_S_KEYS : FIC_S_POLL;
      end
      // [R3] wait for trigger bit to drop
      FIC_S_POLL: if (opDone && !opRdata[trigIdx]) begin
        if (cmd.op == FIC_OP_UNLOCK) begin
          next_progEn = opRdata[`FIC_CTL0_ENA];
          next_cmdErr = ~opRdata[`FIC_CTL0_ENA];
          next_st = FIC_S_FIN;
        end else if (cmd.op == FIC_OP_READ) begin
          next_st = FIC_S_FETCHL;
        end else begin
          next_st = FIC_S_FIN;
        end
      end
      FIC_S_FETCHL: if (opDone) begin
        next_rdWord[7:0] = opRdata;
        next_st = FIC_S_FETCHH;
      end
      FIC_S_FETCHH: if (opDone) begin
        next_rdWord[15:8] = opRdata;
        next_st = FIC_S_FIN;
      end
      FIC_S_FIN: begin
        next_cmdDone = 1'b1;
        next_busy = 1'b0;
        next_st = FIC_S_IDLE;
      end
      default: next_st = FIC_S_IDLE;
    endcase
  end

  // [R11] full core clock, no prescaler
  // Register sequencer state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= FIC_S_IDLE;
      cmd <= '0;
      idx <= 6'h00;
      issued <= 1'b0;
      progEn <= 1'b0;
      clrSeen <= 1'b0;
      busy <= 1'b0;
      cmdDone <= 1'b0;
      cmdErr <= 1'b0;
      rdWord <= 16'h0000;
    end else if (ce) begin
      st <= next_st;
      cmd <= next_cmd;
      idx <= next_idx;
      issued <= next_issued;
      progEn <= next_progEn;
      clrSeen <= next_clrSeen;
      busy <= next_busy;
      cmdDone <= next_cmdDone;
      cmdErr <= next_cmdErr;
      rdWord <= next_rdWord;
    end
  end

  // Device register access engine
  fic_sfr_port u_port (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(opStart),
    .req(req),
    .done(opDone),
    .rdata(opRdata),
    .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata),
    .sfrWr(sfrWr),
    .sfrRd(sfrRd),
    .sfrRdata(sfrRdata)
  );

  // Address of the previous register write, for checking byte order
  always_ff @(posedge core_clk) begin
    if (!rst_b) lastWrAddr <= 8'h00;
    else if (ce && sfrWr) lastWrAddr <= sfrAddr;
  end

  property p_trig_unlocked;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_CTL0 && sfrWdata[`FIC_CTL0_PROG])
      |-> progEn && sfrWdata[`FIC_CTL0_ENA];
  endproperty
  a_trig_unlocked: assert property (p_trig_unlocked) else $error("Trigger while locked"); // [R1]

  property p_erase_mode;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_CTL0 && sfrWdata[`FIC_CTL0_PROG] && cmd.op == FIC_OP_ERASE)
      |-> sfrWdata[`FIC_CTL0_MODE_HI:`FIC_CTL0_MODE_LO] == 3'h1 && clrSeen;
  endproperty
  a_erase_mode: assert property (p_erase_mode) else $error("Erase trigger bad mode or no clear"); // [R2]

  property p_poll_holds;
    @(posedge core_clk) disable iff (!rst_b)
    (ce && st == FIC_S_POLL && opDone && opRdata[trigIdx]) |=> st == FIC_S_POLL;
  endproperty
  a_poll_holds: assert property (p_poll_holds) else $error("Left poll with trigger high"); // [R3]

  property p_write_mode;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_CTL0 && sfrWdata[`FIC_CTL0_PROG] && cmd.op == FIC_OP_WRITE)
      |-> sfrWdata[`FIC_CTL0_MODE_HI:`FIC_CTL0_MODE_LO] == 3'h0;
  endproperty
  a_write_mode: assert property (p_write_mode) else $error("Write trigger bad mode"); // [R4]

  property p_byte_order;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_DAT0H && cmd.op == FIC_OP_WRITE) |-> lastWrAddr == `FIC_DAT0L;
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("High byte without low byte"); // [R5]

  property p_retry_clear;
    @(posedge core_clk) disable iff (!rst_b)
    (ce && st == FIC_S_CHKEN && opDone && opRdata[`FIC_CTL0_ENA] && cmd.clrBuf)
      |=> st == FIC_S_CLRBUF;
  endproperty
  a_retry_clear: assert property (p_retry_clear) else $error("Requested buffer clear skipped"); // [R10]

  property p_read_mode;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_CTL0 && sfrWdata[`FIC_CTL0_RDGO])
      |-> sfrWdata[`FIC_CTL0_MODE_HI:`FIC_CTL0_MODE_LO] == 3'h3 && sfrWdata[`FIC_CTL0_RDEN]
        && $past(sfrAddr) == `FIC_ADRH;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("Read trigger bad setup"); // [R12]

  property p_relock;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_CTL0 && cmd.op == FIC_OP_RELOCK) |-> !sfrWdata[`FIC_CTL0_ENA];
  endproperty
  a_relock: assert property (p_relock) else $error("Relock kept enable flag"); // [R15]

  property p_unlock_start;
    @(posedge core_clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `FIC_DAT1L) |-> sfrWdata == `FIC_KEY0 && cmd.op == FIC_OP_UNLOCK
      && st == FIC_S_KEYS;
  endproperty
  a_unlock_start: assert property (p_unlock_start) else $error("Key write out of sequence"); // [R20]
endmodule

// ### sim/fic_dev_model.sv
// Device model: IAP registers, write buffer and flash array
`timescale 1ns/100ps
`include "fic_regs.svh"
module fic_dev_model #(
  parameter int UNLOCK_CYC = 60,
  parameter int PROG_CYC = 20
) (
  input wire logic core_clk, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic [7:0] sfrAddr, // Register address
  input wire logic [7:0] sfrWdata, // Write data
  input wire logic sfrWr, // Write strobe
  input wire logic sfrRd, // Read strobe
  output logic [7:0] sfrRdata, // Read data, one cycle after strobe
  input wire logic corrupt, // Flip bit 0 of programmed words
  output logic cpuHalt // CPU suspended
);
  logic [15:0] flash [0:8191];
  logic [15:0] wbuf [0:31];
  logic [31:0] wvalid;
  logic [7:0] ctl0, ctl2, adrl, adrh, dlo, dhi, nv;
  logic [7:0] key [0:5];
  logic [7:0] kIdx;
  logic [4:0] ptr;
  logic [12:0] addr;
  int timer, opCnt, clrCnt;
  assign addr = {adrh[4:0], adrl};
  assign kIdx = sfrAddr - `FIC_DAT1L;
  assign cpuHalt = opCnt != 0;
  initial for (int i = 0; i < 8192; i++) flash[i] = 16'hffff;
  // Register read view
  function automatic logic [7:0] rv(input logic [7:0] a);
    case (a)
      `FIC_CTL0: rv = ctl0;
      `FIC_CTL2: rv = ctl2;
      `FIC_ADRL: rv = adrl;
      `FIC_ADRH: rv = adrh;
      `FIC_DAT0L: rv = dlo;
      `FIC_DAT0H: rv = dhi;
      default: rv = 8'h00;
    endcase
  endfunction
  // Register writes and operation timing
  always @(posedge core_clk) begin
    // Read data stands one cycle, then toggles
    sfrRdata <= sfrRd ? rv(sfrAddr) : ~sfrRdata;
    if (!rst_b) begin
      ctl0 <= 8'h00;
      ctl2 <= 8'h00;
      ptr <= 5'h00;
      wvalid <= 32'h0;
      timer <= 0;
      opCnt <= 0;
      clrCnt <= 0;
    end else begin
      if (timer == 1) begin
        ctl0[3] <= 1'b0;
        if ({key[0], key[1], key[2], key[3], key[4], key[5]} == {`FIC_KEY0,
            `FIC_KEY3, `FIC_KEY1, `FIC_KEY4, `FIC_KEY2, `FIC_KEY5})
          ctl0[7] <= 1'b1;
      end
      if (timer != 0) timer <= timer - 1;
      if (clrCnt == 1) begin
        ctl2[0] <= 1'b0;
        wvalid <= 32'h0;
      end
      if (clrCnt != 0) clrCnt <= clrCnt - 1;
      if (opCnt == 1) begin
        if (ctl0[0]) begin
          dlo <= flash[addr][7:0];
          dhi <= flash[addr][15:8];
          ctl0[0] <= 1'b0;
        end else begin
          for (int i = 0; i < 32; i++)
            if (ctl0[6:4] == `FIC_MODE_ERASE)
              flash[{addr[12:5], i[4:0]}] <= 16'h0000;
            else if (wvalid[i])
              flash[{addr[12:5], i[4:0]}] <= wbuf[i] ^ {15'h0, corrupt};
          ctl0[2] <= 1'b0;
        end
      end
      if (opCnt != 0) opCnt <= opCnt - 1;
      if (sfrWr) begin
        case (sfrAddr)
          `FIC_CTL0: begin
            nv = {ctl0[7] & sfrWdata[7], sfrWdata[6:0]};
            // start bit only in unlock mode
            if (nv[3] && nv[6:4] == `FIC_MODE_UNLOCK) begin
              timer <= UNLOCK_CYC;
              for (int i = 0; i < 6; i++) key[i] <= 8'h00;
            end else nv[3] = 1'b0;
            if (nv[2] && ctl0[7] && nv[6:4] <= `FIC_MODE_ERASE) opCnt <= PROG_CYC;
            else nv[2] = 1'b0;
            if (nv[0] && nv[1] && nv[6:4] == `FIC_MODE_READ) opCnt <= 3;
            else nv[0] = 1'b0;
            ctl0 <= nv;
          end
          `FIC_CTL2: if (sfrWdata[0]) begin
            ctl2[0] <= 1'b1;
            clrCnt <= 3;
          end
          `FIC_ADRL: begin
            adrl <= sfrWdata;
            ptr <= sfrWdata[4:0];
          end
          `FIC_ADRH: adrh <= sfrWdata;
          `FIC_DAT0L: dlo <= sfrWdata;
          `FIC_DAT0H: begin
            dhi <= sfrWdata;
            if (ctl0[6:4] == `FIC_MODE_WRITE) begin
              wbuf[ptr] <= {sfrWdata, dlo};
              wvalid[ptr] <= 1'b1;
            end
            if (ptr != 5'h1f) ptr <= ptr + 5'h01;
          end
          default: if (kIdx < 8'h06) key[kIdx] <= sfrWdata;
        endcase
      end
    end
  end
endmodule

// ### sim/flash_iap_controller_test.sv
// Self-checking bench for the flash programming controller
`timescale 1ns/100ps
module flash_iap_controller_test;
  import fic_pkg::*;
  typedef struct {
    fic_op_t op;
    logic [12:0] addr;
    logic [5:0] cnt;
    logic expErr;
    logic [15:0] expRd;
  } fic_row_t;
  logic core_clk, rst_b, ce, cmdValid, bufWr, busy, cmdDone, cmdErr;
  logic sfrWr, sfrRd, corrupt, cpuHalt, err;
  fic_cmd_t cmdIn;
  logic [4:0] bufIdx;
  logic [15:0] bufData, rdWord, rd;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  int miscompares = 0;
  int totalChecks = 0;
  fic_row_t rows [11];
  fic_ctrl u_fic_ctrl (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .cmdValid(cmdValid),
    .cmdIn(cmdIn), .bufWr(bufWr), .bufIdx(bufIdx), .bufData(bufData), .busy(busy),
    .cmdDone(cmdDone), .cmdErr(cmdErr), .rdWord(rdWord), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdata(sfrRdata));
  fic_dev_model u_fic_dev_model (.core_clk(core_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdata(sfrRdata),
    .corrupt(corrupt), .cpuHalt(cpuHalt));
  // Clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compare one value
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Load one word into the host buffer
  task automatic loadWord(input logic [4:0] i, input logic [15:0] d);
    @(negedge core_clk);
    bufWr = 1'b1;
    bufIdx = i;
    bufData = d;
    @(negedge core_clk);
    bufWr = 1'b0;
  endtask
  // Issue one command and wait for its end
  task automatic doCmd(input fic_op_t op, input logic [12:0] a, input logic [5:0] n,
      input logic clr, output logic e, output logic [15:0] w);
    int k;
    logic h, expH;
    h = 1'b0;
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdIn = {op, a, n, clr};
    @(negedge core_clk);
    cmdValid = 1'b0;
    check("busy", {15'h0, busy}, 16'h0001);
    for (k = 0; k < 20000 && cmdDone !== 1'b1; k++) begin
      h = h | cpuHalt;
      @(negedge core_clk);
    end
    if (cmdDone !== 1'b1) begin
      miscompares++;
      summarize();
    end
    e = cmdErr;
    w = rdWord;
    expH = (op == FIC_OP_ERASE || op == FIC_OP_WRITE || op == FIC_OP_READ) && !e;
    check("cpuHalt", {15'h0, h}, {15'h0, expH});
  endtask
  // Hang guard
  initial begin
    #120000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    rows = '{
      '{FIC_OP_READ, 13'h0040, 6'h00, 1'b0, 16'hffff},
      '{FIC_OP_ERASE, 13'h0040, 6'h20, 1'b1, 16'h0000},
      '{FIC_OP_UNLOCK, 13'h0000, 6'h00, 1'b0, 16'h0000},
      '{FIC_OP_ERASE, 13'h0040, 6'h20, 1'b0, 16'h0000},
      '{FIC_OP_READ, 13'h005f, 6'h00, 1'b0, 16'h0000},
      '{FIC_OP_WRITE, 13'h0040, 6'h20, 1'b0, 16'h0000},
      '{FIC_OP_READ, 13'h0040, 6'h00, 1'b0, 16'ha500},
      '{FIC_OP_READ, 13'h005f, 6'h00, 1'b0, 16'ha51f},
      '{FIC_OP_WRITE, 13'h0043, 6'h1e, 1'b1, 16'h0000},
      '{FIC_OP_WRITE, 13'h0040, 6'h00, 1'b1, 16'h0000},
      '{FIC_OP_READ, 13'h0060, 6'h00, 1'b0, 16'hffff}};
    rst_b = 1'b0;
    ce = 1'b1;
    cmdValid = 1'b0;
    cmdIn = '0;
    bufWr = 1'b0;
    bufIdx = 5'h00;
    bufData = 16'h0000;
    corrupt = 1'b0;
    repeat (5) @(negedge core_clk);
    check("reset outputs", {13'h0, busy, cmdDone, sfrWr}, 16'h0000);
    rst_b = 1'b1;
    for (int i = 0; i < 32; i++) loadWord(i[4:0], 16'ha500 + i[15:0]);
    // Table of ordinary commands
    foreach (rows[i]) begin
      doCmd(rows[i].op, rows[i].addr, rows[i].cnt, 1'b0, err, rd);
      check("cmdErr", {15'h0, err}, {15'h0, rows[i].expErr});
      if (rows[i].op == FIC_OP_READ) check("rdWord", rd, rows[i].expRd);
    end
    // Scattered single words in a fresh page
    doCmd(FIC_OP_ERASE, 13'h0080, 6'h20, 1'b0, err, rd);
    loadWord(5'h00, 16'h1111);
    doCmd(FIC_OP_WRITE, 13'h0085, 6'h01, 1'b0, err, rd);
    loadWord(5'h00, 16'h2222);
    doCmd(FIC_OP_WRITE, 13'h009a, 6'h01, 1'b0, err, rd);
    doCmd(FIC_OP_READ, 13'h0085, 6'h00, 1'b0, err, rd);
    check("word 85", rd, 16'h1111);
    doCmd(FIC_OP_READ, 13'h009a, 6'h00, 1'b0, err, rd);
    check("word 9a", rd, 16'h2222);
    doCmd(FIC_OP_READ, 13'h0086, 6'h00, 1'b0, err, rd);
    check("word 86", rd, 16'h0000);
    // Faulty programming, then retry without erase
    corrupt = 1'b1;
    doCmd(FIC_OP_WRITE, 13'h0090, 6'h01, 1'b1, err, rd);
    corrupt = 1'b0;
    doCmd(FIC_OP_READ, 13'h0090, 6'h00, 1'b0, err, rd);
    check("faulty word", rd, 16'h2223);
    doCmd(FIC_OP_WRITE, 13'h0090, 6'h01, 1'b1, err, rd);
    check("retry err", {15'h0, err}, 16'h0000);
    doCmd(FIC_OP_READ, 13'h0090, 6'h00, 1'b0, err, rd);
    check("retried word", rd, 16'h2222);
    // Relock, then programming is refused
    doCmd(FIC_OP_RELOCK, 13'h0000, 6'h00, 1'b0, err, rd);
    doCmd(FIC_OP_WRITE, 13'h0090, 6'h01, 1'b0, err, rd);
    check("locked write", {15'h0, err}, 16'h0001);
    doCmd(FIC_OP_READ, 13'h0090, 6'h00, 1'b0, err, rd);
    check("locked read", rd, 16'h2222);
    summarize();
  end
endmodule
